// File: bus_ready_ctrl.sv
`timescale 1ns/100ps
`include "bus_ready_regs.svh"

module bus_ready_ctrl
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link clock (separate clock of the link logic that flags each accepted ready event)
  input wire logic link_clk,
  // configuration
  input wire logic ready_active_high,
  input wire logic ready_async_mode,
  input wire logic ready_enable,
  input wire logic [`PHASE_W-1:0] mandatory_wait_phase,
  // request from core
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`ADDR_W-1:0] req_addr,
  input wire logic [`DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic done_pulse,
  output logic [`DATA_W-1:0] rdata,
  // bus pins
  input wire logic ready_pin,
  input wire logic [`DATA_W-1:0] data_in,
  output logic [`DATA_W-1:0] data_out,
  output logic data_oe,
  output logic [`ADDR_W-1:0] addr_out,
  output logic rd_n,
  output logic wr_n,
  output logic reference_clock_output,
  output logic ready_wait_phase,
  output logic ready_seen_link
);

  // ----------------------------------------------------------------
  // reference clock and ready input conditioning
  // ----------------------------------------------------------------
  logic clk_ref;
  logic ref_rise;
  logic ready_async_lvl;
  logic ready_s1_reg;
  logic ready_s2_reg;
  logic ready_s1_next;
  logic ready_s2_next;
  logic [`DATA_W-1:0] data_s1_reg;
  logic [`DATA_W-1:0] data_s2_reg;
  logic [`DATA_W-1:0] data_s1_next;
  logic [`DATA_W-1:0] data_s2_next;

  refclk_gen u_refclk
  (
    .mclk(mclk),
    .resetn(resetn),
    .clk_out(clk_ref),
    .rise_pulse(ref_rise)
  );

  // two extra sync stages for async mode; their output drives async decision
  ready_sync u_async
  (
    .mclk(mclk),
    .resetn(resetn),
    .pin_in(ready_s2_reg),
    .level_out(ready_async_lvl)
  );

  // pins pass two flops; the data flops shift on every mclk, strobe or not
  always_comb
  begin
    ready_s1_next = ready_pin;
    ready_s2_next = ready_s1_reg;
    data_s1_next = data_in;
    data_s2_next = data_s1_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ready_s1_reg <= 1'b0;
      ready_s2_reg <= 1'b0;
      data_s1_reg <= '0;
      data_s2_reg <= '0;
    end
    else
    begin
      ready_s1_reg <= ready_s1_next;
      ready_s2_reg <= ready_s2_next;
      data_s1_reg <= data_s1_next;
      data_s2_reg <= data_s2_next;
    end
  end

  // polarity applied to whichever sample the mode selects
  function automatic logic ready_active(input logic lvl, input logic pol);
    ready_active = pol ? lvl : !lvl;
  endfunction

  logic ready_sync_ok;
  logic ready_async_ok;
  assign ready_sync_ok = ready_active(ready_s2_reg, ready_active_high);
  assign ready_async_ok = ready_active(ready_async_lvl, ready_active_high);

  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  bus_ready_pkg::cycle_state_t st_reg;
  bus_ready_pkg::cycle_state_t st_next;
  logic [`PHASE_W-1:0] wcnt_reg;
  logic [`PHASE_W-1:0] wcnt_next;
  logic [`ADDR_W-1:0] addr_reg;
  logic [`ADDR_W-1:0] addr_next;
  logic [`DATA_W-1:0] wdata_reg;
  logic [`DATA_W-1:0] wdata_next;
  logic [`DATA_W-1:0] rdata_reg;
  logic [`DATA_W-1:0] rdata_next;
  logic write_reg;
  logic write_next;
  logic rd_n_reg;
  logic rd_n_next;
  logic wr_n_reg;
  logic wr_n_next;
  logic oe_reg;
  logic oe_next;
  logic done_reg;
  logic done_next;
  logic rwait_reg;
  logic rwait_next;
  logic rdy_tog_reg;
  logic rdy_tog_next;

  // steps only on reference clock rises so the responder sees
  // ready sampled against the clock it is synchronous to
  always_comb
  begin
    st_next = st_reg;
    wcnt_next = wcnt_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    write_next = write_reg;
    rd_n_next = rd_n_reg;
    wr_n_next = wr_n_reg;
    oe_next = oe_reg;
    done_next = 1'b0;
    rwait_next = rwait_reg;
    rdy_tog_next = rdy_tog_reg;
    unique case (st_reg)
      bus_ready_pkg::st_idle:
      begin
        if (req_valid && ref_rise)
        begin
          addr_next = req_addr;
          wdata_next = req_wdata;
          write_next = req_write;
          oe_next = req_write;
          st_next = bus_ready_pkg::st_addr;
        end
      end
      bus_ready_pkg::st_addr:
      begin
        if (ref_rise)
        begin
          rd_n_next = write_reg;
          wr_n_next = !write_reg;
          wcnt_next = mandatory_wait_phase;
          st_next = bus_ready_pkg::st_wait;
        end
      end
      bus_ready_pkg::st_wait:
      begin
        // no ready check while mandatory waits run
        if (ref_rise)
        begin
          if (wcnt_reg != '0)
            wcnt_next = wcnt_reg - `PHASE_W'(1);
          else if (!ready_enable)
            st_next = bus_ready_pkg::st_end;
          else if (ready_async_mode)
            st_next = bus_ready_pkg::st_sync;
          else
            st_next = bus_ready_pkg::st_sample;
        end
      end
      bus_ready_pkg::st_sync:
      begin
        // one extra clock period lets the sync stage settle
        if (ref_rise)
          st_next = bus_ready_pkg::st_sample;
      end
      bus_ready_pkg::st_sample:
      begin
        if (ref_rise)
        begin
          if (ready_async_mode ? ready_async_ok : ready_sync_ok)
          begin
            rwait_next = 1'b0;
            rdy_tog_next = !rdy_tog_reg;
            st_next = bus_ready_pkg::st_end;
          end
          else
            rwait_next = 1'b1;
        end
      end
      bus_ready_pkg::st_end:
      begin
        if (ref_rise)
        begin
          if (!write_reg)
            rdata_next = data_s2_reg;
          rd_n_next = 1'b1;
          wr_n_next = 1'b1;
          oe_next = 1'b0;
          done_next = 1'b1;
          st_next = bus_ready_pkg::st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      st_reg <= bus_ready_pkg::st_idle;
      wcnt_reg <= '0;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      write_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      oe_reg <= 1'b0;
      done_reg <= 1'b0;
      rwait_reg <= 1'b0;
      rdy_tog_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      wcnt_reg <= wcnt_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      write_reg <= write_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      oe_reg <= oe_next;
      done_reg <= done_next;
      rwait_reg <= rwait_next;
      rdy_tog_reg <= rdy_tog_next;
    end
  end

  // ----------------------------------------------------------------
  // link clock domain: acknowledge event seen by link logic
  // ----------------------------------------------------------------
  logic [2:0] lk_sync_reg;
  logic [2:0] lk_sync_next;
  logic lk_seen_reg;
  logic lk_seen_next;

  // toggle crossing; first stage read only by the second
  always_comb
  begin
    lk_sync_next = {lk_sync_reg[1:0], rdy_tog_reg};
    lk_seen_next = lk_sync_reg[2] ^ lk_sync_reg[1];
  end

  always_ff @(posedge link_clk)
  begin
    if (!resetn)
    begin
      lk_sync_reg <= '0;
      lk_seen_reg <= 1'b0;
    end
    else
    begin
      lk_sync_reg <= lk_sync_next;
      lk_seen_reg <= lk_seen_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  logic ready_q;
  logic ready_q_next;
  assign ready_q_next = (st_next == bus_ready_pkg::st_idle);

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      ready_q <= 1'b0;
    else
      ready_q <= ready_q_next;
  end

  assign req_ready = ready_q;
  assign done_pulse = done_reg;
  assign rdata = rdata_reg;
  assign data_out = wdata_reg;
  assign data_oe = oe_reg;
  assign addr_out = addr_reg;
  assign rd_n = rd_n_reg;
  assign wr_n = wr_n_reg;
  assign reference_clock_output = clk_ref;
  assign ready_wait_phase = rwait_reg;
  assign ready_seen_link = lk_seen_reg;

endmodule

// File: bus_ready_ctrl_monitor.sv
`timescale 1ns/100ps
`include "bus_ready_regs.svh"

module bus_ready_ctrl_monitor
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // watched ports
  input wire logic [`PHASE_W-1:0] mandatory_wait_phase,
  input wire logic [`DATA_W-1:0] rdata,
  input wire logic done_pulse,
  input wire logic req_ready,
  input wire logic data_oe,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ready_wait_phase
);
  logic strobe;
  logic [11:0] low_reg;
  logic [11:0] low_next;

  // length of the running strobe, in mclk samples
  assign strobe = !rd_n || !wr_n;
  always_comb low_next = strobe ? low_reg + 12'h001 : 12'h000;
  always_ff @(posedge mclk) low_reg <= resetn ? low_next : 12'h000;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // the strobe trailing edge closes a cycle
  sequence strobe_end;
    $rose(rd_n) || $rose(wr_n);
  endsequence

  end_done_a: assert property (strobe_end |-> done_pulse)
    else $error("strobe rose without done");
  done_once_a: assert property (done_pulse |=> !done_pulse)
    else $error("done longer than one cycle");
  wait_hold_a: assert property (ready_wait_phase |-> strobe)
    else $error("ready wait outside a strobe");
  wait_mand_a: assert property (strobe_end |->
    low_reg >= 4 * (mandatory_wait_phase + 1))
    else $error("cycle ended before mandatory waits");
  rdata_hold_a: assert property (!$rose(rd_n) |-> $stable(rdata))
    else $error("read data moved off the strobe edge");
  read_release_a: assert property (!rd_n |-> !data_oe)
    else $error("bus driven during a read");
  idle_req_a: assert property (req_ready |-> !strobe)
    else $error("idle while a strobe is active");
  wait_end_a: assert property ($fell(ready_wait_phase) |->
    ##[0:12] done_pulse)
    else $error("ready wait ended without cycle end");
endmodule

bind bus_ready_ctrl bus_ready_ctrl_monitor bus_ready_ctrl_monitor_inst
(
  .mclk(mclk), .resetn(resetn), .mandatory_wait_phase(mandatory_wait_phase),
  .rdata(rdata), .done_pulse(done_pulse), .req_ready(req_ready),
  .data_oe(data_oe), .rd_n(rd_n), .wr_n(wr_n),
  .ready_wait_phase(ready_wait_phase)
);

// File: bus_ready_ctrl_test.sv
`timescale 1ns/100ps
`include "bus_ready_regs.svh"

module bus_ready_ctrl_test;
  typedef struct packed
  {
    logic a;
    logic p;
    logic [3:0] m;
    logic [3:0] d;
    logic w;
    logic x;
    logic [15:0] v;
  } row_t;
  row_t rows [6] = '{
    '{1'b0, 1'b1, 4'h0, 4'h0, 1'b0, 1'b0, 16'hA55A},
    '{1'b1, 1'b1, 4'h0, 4'h0, 1'b0, 1'b0, 16'h5AA5},
    '{1'b0, 1'b0, 4'h2, 4'h0, 1'b1, 1'b0, 16'h1234},
    '{1'b1, 1'b0, 4'h2, 4'h0, 1'b1, 1'b0, 16'hFEDC},
    '{1'b0, 1'b1, 4'h1, 4'h3, 1'b0, 1'b1, 16'h00FF},
    '{1'b1, 1'b0, 4'h1, 4'h3, 1'b1, 1'b1, 16'hFF00}};
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic async_m, pol, req_valid, req_write, rsp_pol, seen;
  logic req_ready, done_pulse, data_oe, rd_n, wr_n, ref_clk, ready_pin;
  logic wait_ph, seen_link, link_q;
  logic rdy_en = 1'b1;
  int refs = 0;
  int refs0, n0;
  logic [3:0] mwp, rsp_dly;
  logic [`ADDR_W-1:0] req_addr, addr_out;
  logic [`DATA_W-1:0] req_wdata, rsp_word, rdata, data_in, data_out;
  int num_errors = 0;
  int total_checks = 0;
  int len, links = 0;
  int lens [6];

  // clocks; the link clock starts off the mclk grid
  always #4 mclk = ~mclk;
  initial
  begin
    #3;
    forever #16 link_clk = ~link_clk;
  end

  // accepted ready pulses seen in the link domain
  always @(posedge link_clk)
  begin
    link_q <= seen_link;
    if (seen_link && !link_q)
      links <= links + 1;
  end

  // reference clock rises, to check its rate
  always @(posedge ref_clk)
    refs <= refs + 1;

  bus_ready_ctrl bus_ready_ctrl_inst
  (
    .mclk(mclk), .resetn(resetn), .link_clk(link_clk),
    .ready_active_high(pol), .ready_async_mode(async_m),
    .ready_enable(rdy_en), .mandatory_wait_phase(mwp),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .done_pulse(done_pulse),
    .rdata(rdata), .ready_pin(ready_pin), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .addr_out(addr_out),
    .rd_n(rd_n), .wr_n(wr_n), .reference_clock_output(ref_clk),
    .ready_wait_phase(wait_ph), .ready_seen_link(seen_link)
  );

  ready_responder ready_responder_inst
  (
    .ref_clk(ref_clk), .rd_n(rd_n), .wr_n(wr_n), .ready_pin(ready_pin),
    .data_in(data_in), .active_high(rsp_pol), .delay(rsp_dly),
    .word(rsp_word)
  );

  task check(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one bus cycle; inv sets the responder to the wrong polarity
  task run(input row_t r, input logic inv);
    int n;
    @(posedge mclk);
    #1;
    {async_m, pol, rsp_pol} = {r.a, r.p, r.p ^ inv};
    {mwp, rsp_dly, req_write} = {r.m, r.d, r.w};
    {req_addr, req_wdata, rsp_word} = {8'h00, r.v, r.v, r.v};
    req_valid = 1'b1;
    {len, n, seen} = {32'h0, 32'h0, 1'b0};
    while (done_pulse !== 1'b1)
    begin
      @(posedge mclk);
      #1;
      n++;
      if (!rd_n || !wr_n)
      begin
        len++;
        check(24'({req_ready, data_oe}), 24'({1'b0, r.w}));
      end
      if (wait_ph === 1'b1)
        seen = 1'b1;
      if (n > 2000)
      begin
        num_errors++;
        final_report;
      end
    end
    req_valid = 1'b0;
    check(addr_out, {8'h00, r.v});
    if (r.w)
      check(24'(data_out), 24'(r.v));
    else
      check(24'(rdata), 24'(r.v));
    check(24'(seen), 24'(r.x && !inv && rdy_en));
  endtask

  initial
  begin
    {async_m, pol, req_valid, req_write, rsp_pol} = 5'h09;
    {mwp, rsp_dly, req_addr} = {8'h00, 24'h000000};
    {req_wdata, rsp_word} = 32'h00000000;
    repeat (3) @(posedge mclk);
    #1;
    check(24'({req_ready, rd_n, wr_n, data_oe}), 24'h6);
    repeat (2) @(posedge mclk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      run(rows[i], 1'b0);
      lens[i] = len;
    end
    check(24'(lens[1] > lens[0] + 3), 24'h1);
    check(24'(lens[3] > lens[2] + 3), 24'h1);
    check(24'(lens[2] >= lens[0] + 8), 24'h1);
    check(24'(lens[4] > lens[0]), 24'h1);
    // wrong polarity reads the idle level as ready and ends early
    run(rows[4], 1'b1);
    check(24'(len < lens[4]), 24'h1);
    // without ready control the cycle ends after the mandatory waits
    rdy_en = 1'b0;
    run(rows[4], 1'b0);
    check(24'(len), 24'(4 * (rows[4].m + 2)));
    rdy_en = 1'b1;
    refs0 = refs;
    repeat (40) @(posedge mclk);
    #1;
    check(24'(links), 24'h7);
    check(24'(refs - refs0), 24'hA);
    // reset in the middle of a cycle drops the strobe on the next mclk edge
    {mwp, req_write, req_valid} = {4'h4, 1'b0, 1'b1};
    n0 = 0;
    while (rd_n === 1'b1)
    begin
      @(posedge mclk);
      #1;
      n0++;
      if (n0 > 100)
      begin
        num_errors++;
        final_report;
      end
    end
    resetn = 1'b0;
    req_valid = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    check(24'({req_ready, rd_n, wr_n, data_oe}), 24'h6);
    resetn = 1'b1;
    @(posedge mclk);
    #1;
    check(24'(req_ready), 24'h1);
    run(rows[0], 1'b0);
    repeat (40) @(posedge mclk);
    #1;
    check(24'(links), 24'h8);
    final_report;
  end
endmodule

// File: bus_ready_pkg.sv
package bus_ready_pkg;
  // bus cycle sequencer states, one-hot
  typedef enum logic [5:0]
  {
    st_idle = 6'h01,
    st_addr = 6'h02,
    st_wait = 6'h04,
    st_sample = 6'h08,
    st_sync = 6'h10,
    st_end = 6'h20
  } cycle_state_t;
endpackage

// File: bus_ready_regs.svh
`ifndef BUS_READY_REGS_SVH
`define BUS_READY_REGS_SVH

// ----------------------------------------------------------------
// widths, reset values and timing counts
// ----------------------------------------------------------------
`define PHASE_W 4
`define DATA_W 16
`define ADDR_W 24
`define SYNC_STAGES 2
`define ASYNC_EXTRA_WAIT 1
`define READY_POL_RESET 1'b0
`define REFCLK_DIV 4
`define REFCLK_DIV_W 2

`endif

// File: ready_responder.sv
`timescale 1ns/100ps
`include "bus_ready_regs.svh"

module ready_responder
(
  // bus side
  input wire logic ref_clk,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic ready_pin,
  output logic [`DATA_W-1:0] data_in,
  // behaviour chosen by the bench
  input wire logic active_high,
  input wire logic [3:0] delay,
  input wire logic [`DATA_W-1:0] word
);
  logic [3:0] cnt = 4'h0;
  logic ack = 1'b0;

  // half a period off the rising edge, so setup holds in sync mode
  always @(negedge ref_clk)
  begin
    cnt <= (rd_n && wr_n) ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
    ack <= !(rd_n && wr_n) && cnt >= delay;
  end

  // level per polarity; released data shows the inverse, never stale
  assign ready_pin = active_high ? ack : !ack;
  assign data_in = rd_n ? ~word : word;
endmodule

// File: ready_sync.sv
`timescale 1ns/100ps
`include "bus_ready_regs.svh"

module ready_sync
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // pin level and synchronised level
  input wire logic pin_in,
  output logic level_out
);

  logic [`SYNC_STAGES-1:0] chain_reg;
  logic [`SYNC_STAGES-1:0] chain_next;

  // shift chain; only the last stage is read outside
  always_comb
  begin
    chain_next = {chain_reg[`SYNC_STAGES-2:0], pin_in};
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      chain_reg <= '0;
    else
      chain_reg <= chain_next;
  end

  assign level_out = chain_reg[`SYNC_STAGES-1];

endmodule

// File: reference_clock_output_gen.sv
`timescale 1ns/100ps
`include "bus_ready_regs.svh"

module refclk_gen
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // divided clock and its rising-edge strobe
  output logic clk_out,
  output logic rise_pulse
);

  logic [`REFCLK_DIV_W-1:0] cnt_reg;
  logic [`REFCLK_DIV_W-1:0] cnt_next;
  logic clk_reg;
  logic clk_next;
  logic rise_reg;
  logic rise_next;

  // reference clock is mclk divided, so it is no second domain
  always_comb
  begin
    cnt_next = cnt_reg + `REFCLK_DIV_W'(1);
    clk_next = (cnt_next < `REFCLK_DIV_W'(`REFCLK_DIV / 2));
    rise_next = clk_next && !clk_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      cnt_reg <= '0;
      clk_reg <= 1'b0;
      rise_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
      rise_reg <= rise_next;
    end
  end

  assign clk_out = clk_reg;
  assign rise_pulse = rise_reg;

endmodule
